// [verilog/iccb_dev_end.sv]
// Amplifier end: serial control port, register file and coefficient banks
`timescale 1ns/1ns
`include "iccb_map.svh"

//How it works
// - Write address with direction zero is acknowledged
// - Subaddress byte follows address, is acknowledged
// - Every written data byte is acknowledged
// - Master ends each write with stop
// - Read: subaddress write, repeated start, read address
// - Read byte at subaddress driven MSB first
// - Master ends read with nack then stop
// - Keep sending bytes while master acknowledges
// - Three banks: 32k, 44.1/48k, other rates
// - Bank field zero: coefficient writes go live
// - Codes one to three: writes update stored bank
// - Code four: auto load bank on rate change
// - Controller loads all banks before auto mode
// - Headphone mode bypasses equaliser and range control
// - Trim register zero applies factory oscillator trim
// - Shutdown bit six low releases shutdown
// - Volume code 30 hex means unity gain
// - Five 26-bit 3.23 coefficients per biquad
// - Answer only to slave address 0011011
// - Partial biquad write is discarded
// - Narrow registers read zeros in upper bits
module iccb_dev_end
    import iccb_pkg::*;
#(
    parameter int N_BQ = 23
)(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    iccb_bus_if.dev         bus,
    input  wire logic [1:0] i_fs_class,
    input  wire logic       i_headphone,
    input  wire logic [6:0] i_coef_idx,
    output logic            o_shutdown,
    output logic            o_osc_factory_trim,
    output logic            o_unity_gain,
    output logic [7:0]      o_volume,
    output logic            o_vol_comp_en,
    output logic            o_eq_bypass,
    output logic            o_drc_bypass,
    output logic            o_auto_bank,
    output logic [1:0]      o_bank_live,
    output iccb_coef_t      o_coef
);
    localparam int NW = N_BQ * `ICCB_BQ_WORDS;

    // Bytes a subaddress takes before the pointer moves on
    function automatic logic [4:0] reg_len(input logic [7:0] a);
        if (a >= `ICCB_SUB_BQ_FIRST && a <= `ICCB_SUB_BQ_LAST) return `ICCB_LEN_BQ;
        if (a == `ICCB_SUB_LINV || a == `ICCB_SUB_LSCALE || a == `ICCB_SUB_BANKCTL)
            return `ICCB_LEN_WORD;
        return `ICCB_LEN_BYTE;
    endfunction

    logic        scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic        hp_m, hp_s;
    logic [1:0]  fs_m, fs_s, live_r;
    logic        auto_prev_r;
    iccb_dst_e   state_r;
    logic [3:0]  bitcnt_r;
    logic [7:0]  rx_r, tx_r, ptr_r;
    logic [4:0]  bcnt_r;
    logic        sda_oe_n_r;
    logic [23:0] wacc_r;
    iccb_coef_t  wbuf_r [`ICCB_BQ_WORDS];
    logic [7:0]  shut_r, vol_r, vcomp_r, trim_r;
    logic [31:0] linv_r, lscale_r, rd_word;
    logic [2:0]  bank_r;
    iccb_coef_t  coef_act_r [NW];
    iccb_coef_t  coef_bank_r [3][NW];

    // ==========================================================
    // Bus event decode on synchronised lines
    wire scl_rise  = scl_s & ~scl_p;
    wire scl_fall  = ~scl_s & scl_p;
    wire start_c   = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_c    = scl_s & scl_p & ~sda_p & sda_s;
    wire active    = (state_r != D_IDLE) && (state_r != D_SKIP);
    wire is_bq     = reg_len(ptr_r) == `ICCB_LEN_BQ;
    wire last_byte = (bcnt_r + 5'h01) == reg_len(ptr_r);
    wire [7:0] ptr_adv  = last_byte ? ptr_r + 8'h01 : ptr_r;
    wire [4:0] bcnt_adv = last_byte ? 5'h00 : bcnt_r + 5'h01;
    wire [31:0] wword   = {wacc_r, rx_r};
    wire wr_fire   = active & scl_fall & (bitcnt_r == 4'h8) & (state_r == D_WR);
    wire wr_last   = wr_fire & last_byte;
    wire bq_commit = wr_last & is_bq;
    wire [6:0] bq_base = 7'((ptr_r - `ICCB_SUB_BQ_FIRST) * 8'h05);
    wire [6:0] rd_idx  = bq_base + 7'(bcnt_r[4:2]);
    wire [1:0] rd_sel  = (reg_len(ptr_r) == `ICCB_LEN_BYTE) ? 2'h0 : 2'h3 - bcnt_r[1:0];
    wire [7:0] rd_byte = rd_word[8 * rd_sel +: 8];
    wire to_bank   = (bank_r >= `ICCB_BANK_U1) && (bank_r <= `ICCB_BANK_U3);
    wire [1:0] bank_idx = 2'(bank_r - `ICCB_BANK_U1);
    wire [1:0] fs_bank  = (fs_s == FS_32K) ? 2'h0 : (fs_s == FS_48K) ? 2'h1 : 2'h2;
    wire is_auto   = bank_r == `ICCB_BANK_AUTO;
    wire auto_load = is_auto & (~auto_prev_r | (fs_bank != live_r));

    // Read word; bits beyond a register's width read as zero
    always_comb begin
        rd_word = 32'h0;
        case (ptr_r)
            `ICCB_SUB_SHUTDOWN: rd_word = {24'h0, shut_r};
            `ICCB_SUB_VOLUME:   rd_word = {24'h0, vol_r};
            `ICCB_SUB_VCOMP:    rd_word = {24'h0, vcomp_r};
            `ICCB_SUB_TRIM:     rd_word = {24'h0, trim_r};
            `ICCB_SUB_LINV:     rd_word = linv_r;
            `ICCB_SUB_LSCALE:   rd_word = lscale_r;
            `ICCB_SUB_BANKCTL:  rd_word = {29'h0, bank_r};
            default: begin
                if (is_bq) rd_word = {6'h0, coef_act_r[rd_idx]};
            end
        endcase
    end

    // ==========================================================
    // Two-flop synchronisers; the third stage only keeps history
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3f;
            {hp_m, hp_s} <= 2'h0;
            {fs_m, fs_s} <= 4'h0;
        end else begin
            {scl_m, scl_s, scl_p} <= {bus.scl, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {bus.sda, sda_m, sda_s};
            {hp_m, hp_s} <= {i_headphone, hp_m};
            {fs_m, fs_s} <= {i_fs_class, fs_m};
        end
    end

    // ==========================================================
    // Protocol engine: bits on rising edges, drive on falling edges
    // A new start or stop clears the byte count, so half a set is lost
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r    <= D_IDLE;
            bitcnt_r   <= 4'h0;
            rx_r       <= 8'h0;
            tx_r       <= 8'h0;
            ptr_r      <= 8'h0;
            bcnt_r     <= 5'h0;
            sda_oe_n_r <= 1'b1;
            wacc_r     <= 24'h0;
        end else if (start_c) begin
            state_r    <= D_ADDR;
            bitcnt_r   <= 4'h0;
            bcnt_r     <= 5'h0;
            sda_oe_n_r <= 1'b1;
        end else if (stop_c) begin
            state_r    <= D_IDLE;
            bcnt_r     <= 5'h0;
            sda_oe_n_r <= 1'b1;
        end else if (active && scl_rise) begin
            if (bitcnt_r < 4'h8) begin
                rx_r     <= {rx_r[6:0], sda_s};
                bitcnt_r <= bitcnt_r + 4'h1;
            end else begin
                bitcnt_r <= 4'h9;
                if (state_r == D_RD && bitcnt_r == 4'h8) begin
                    if (sda_s) begin
                        state_r <= D_SKIP;
                    end else begin
                        ptr_r  <= ptr_adv;
                        bcnt_r <= bcnt_adv;
                    end
                end
            end
        end else if (active && scl_fall) begin
            if (bitcnt_r == 4'h8) begin
                case (state_r)
                    D_ADDR: begin
                        if (rx_r[7:1] == `ICCB_DEV_ADDR) begin
                            sda_oe_n_r <= 1'b0;
                            state_r    <= rx_r[0] ? D_RD : D_SUB;
                            // Our own ack slot must not move the read pointer
                            if (rx_r[0]) bitcnt_r <= 4'ha;
                        end else begin
                            state_r <= D_SKIP;
                        end
                    end
                    D_SUB: begin
                        sda_oe_n_r <= 1'b0;
                        ptr_r      <= rx_r;
                        bcnt_r     <= 5'h0;
                        state_r    <= D_WR;
                    end
                    D_WR: begin
                        sda_oe_n_r <= 1'b0;
                        wacc_r     <= wword[23:0];
                        ptr_r      <= ptr_adv;
                        bcnt_r     <= bcnt_adv;
                    end
                    default: sda_oe_n_r <= 1'b1;
                endcase
            end else if (bitcnt_r == 4'h9) begin
                bitcnt_r <= 4'h0;
                if (state_r == D_RD) begin
                    tx_r       <= rd_byte;
                    sda_oe_n_r <= rd_byte[7];
                end else begin
                    sda_oe_n_r <= 1'b1;
                end
            end else if (state_r == D_RD) begin
                sda_oe_n_r <= tx_r[3'(4'h7 - bitcnt_r)];
            end
        end
    end

    // ==========================================================
    // Register file: a register changes only once its set is complete
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            shut_r   <= `ICCB_RST_SHUTDOWN;
            vol_r    <= `ICCB_RST_VOLUME;
            vcomp_r  <= 8'h0;
            trim_r   <= `ICCB_RST_TRIM;
            linv_r   <= 32'h0;
            lscale_r <= 32'h0;
            bank_r   <= `ICCB_RST_BANKCTL;
            for (int i = 0; i < `ICCB_BQ_WORDS; i++) wbuf_r[i] <= '0;
        end else if (wr_fire) begin
            if (bcnt_r[1:0] == 2'h3) wbuf_r[bcnt_r[4:2]] <= wword[25:0];
            if (last_byte) begin
                case (ptr_r)
                    `ICCB_SUB_SHUTDOWN: shut_r   <= rx_r;
                    `ICCB_SUB_VOLUME:   vol_r    <= rx_r;
                    `ICCB_SUB_VCOMP:    vcomp_r  <= rx_r;
                    `ICCB_SUB_TRIM:     trim_r   <= rx_r;
                    `ICCB_SUB_LINV:     linv_r   <= wword;
                    `ICCB_SUB_LSCALE:   lscale_r <= wword;
                    `ICCB_SUB_BANKCTL:  bank_r   <= rx_r[2:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // Coefficient store: live set plus three rate banks, no reset
    // The whole bank is copied in one edge; costs area, avoids a mixed set
    always_ff @(posedge i_ref_clk) begin
        if (auto_load) begin
            for (int k = 0; k < NW; k++) coef_act_r[k] <= coef_bank_r[fs_bank][k];
        end
        if (bq_commit) begin
            for (int w = 0; w < `ICCB_BQ_WORDS; w++) begin
                if (to_bank)
                    coef_bank_r[bank_idx][bq_base + 7'(w)] <=
                        (w == 4) ? wword[25:0] : wbuf_r[w];
                else
                    coef_act_r[bq_base + 7'(w)] <=
                        (w == 4) ? wword[25:0] : wbuf_r[w];
            end
        end
    end

    // ==========================================================
    // Core-facing state; entering auto mode loads the current bank at once
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            auto_prev_r        <= 1'b0;
            live_r             <= 2'h0;
            o_osc_factory_trim <= 1'b0;
            o_unity_gain       <= 1'b0;
            o_eq_bypass        <= 1'b0;
            o_drc_bypass       <= 1'b0;
            o_auto_bank        <= 1'b0;
            o_coef             <= '0;
        end else begin
            auto_prev_r <= is_auto;
            if (auto_load) live_r <= fs_bank;
            o_osc_factory_trim <= trim_r == `ICCB_TRIM_FACTORY;
            o_unity_gain       <= vol_r == `ICCB_VOL_UNITY;
            o_eq_bypass        <= hp_s;
            o_drc_bypass       <= hp_s;
            o_auto_bank        <= is_auto;
            o_coef             <= coef_act_r[i_coef_idx];
        end
    end

    assign o_shutdown     = shut_r[`ICCB_SHUTDOWN_BIT];
    assign o_volume       = vol_r;
    assign o_vol_comp_en  = vcomp_r[0];
    assign o_bank_live    = live_r;
    assign bus.s_sda_oe_n = sda_oe_n_r;
endmodule

// [verilog/iccb_map.svh]
// Constants of the control port: subaddresses, fields, reset values and timing
`ifndef ICCB_MAP_SVH
`define ICCB_MAP_SVH

// ==========================================================
// Bus identity and subaddresses
`define ICCB_DEV_ADDR       7'h1b
`define ICCB_SUB_SHUTDOWN   8'h05
`define ICCB_SUB_VOLUME     8'h07
`define ICCB_SUB_VCOMP      8'h0e
`define ICCB_SUB_TRIM       8'h1b
`define ICCB_SUB_LINV       8'h26
`define ICCB_SUB_LSCALE     8'h28
`define ICCB_SUB_BQ_FIRST   8'h29
`define ICCB_SUB_BQ_LAST    8'h3f
`define ICCB_SUB_BANKCTL    8'h50

// ==========================================================
// Fields and codes
`define ICCB_SHUTDOWN_BIT   6
`define ICCB_VOL_UNITY      8'h30
`define ICCB_TRIM_FACTORY   8'h00
`define ICCB_BANK_OFF       3'h0
`define ICCB_BANK_U1        3'h1
`define ICCB_BANK_U3        3'h3
`define ICCB_BANK_AUTO      3'h4
`define ICCB_COEF_W         26
`define ICCB_BQ_WORDS       5
`define ICCB_LEN_BYTE       5'h01
`define ICCB_LEN_WORD       5'h04
`define ICCB_LEN_BQ         5'h14

// ==========================================================
// Reset values
`define ICCB_RST_SHUTDOWN   8'h40
`define ICCB_RST_VOLUME     8'h00
`define ICCB_RST_TRIM       8'hff
`define ICCB_RST_BANKCTL    3'h0

// ==========================================================
// Timing: quarter of a bus bit period, a least time, rounded up
`define ICCB_REF_CLK_NS     50
`define ICCB_SCL_QUARTER_NS 250
`define ICCB_SCL_QUARTER_CYC \
    ((`ICCB_SCL_QUARTER_NS + `ICCB_REF_CLK_NS - 1) / `ICCB_REF_CLK_NS)

`endif

// [verilog/iccb_pkg.sv]
// Types shared by both ends of the control port
package iccb_pkg;
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_SUB, D_WR, D_RD, D_SKIP} iccb_dst_e;
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} iccb_hst_e;
    typedef enum logic [1:0] {FS_32K, FS_48K, FS_OTHER, FS_OTHER2} iccb_fs_e;
    typedef logic [25:0] iccb_coef_t;
endpackage

// [verilog/iccb_bus_if.sv]
// Two-wire control bus joining master end and amplifier end
`timescale 1ns/1ns
interface iccb_bus_if;
    logic m_scl_oe_n;
    logic m_sda_oe_n;
    logic s_sda_oe_n;
    logic scl;
    logic sda;

    // ==========================================================
    // Wired-AND with pull-ups: a low enable pulls the line low
    assign scl = m_scl_oe_n;
    assign sda = m_sda_oe_n & s_sda_oe_n;

    modport host(output m_scl_oe_n, output m_sda_oe_n, input scl, input sda);
    modport dev(output s_sda_oe_n, input scl, input sda);
endinterface

// [verilog/iccb_host_end.sv]
// Master end: issues one write or read transfer per request
`timescale 1ns/1ns
`include "iccb_map.svh"

module iccb_host_end
    import iccb_pkg::*;
#(
    parameter int QCYC = `ICCB_SCL_QUARTER_CYC
)(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    iccb_bus_if.host        bus,
    input  wire logic       i_go,
    input  wire logic       i_read,
    input  wire logic [7:0] i_sub,
    input  wire logic [5:0] i_count,
    input  wire logic [7:0] i_wbyte,
    output logic            o_wtake,
    output logic [7:0]      o_rbyte,
    output logic            o_rvalid,
    output logic            o_busy,
    output logic            o_nack,
    output logic            o_done
);
    iccb_hst_e   st_r;
    logic [15:0] q_r;
    logic [1:0]  ph_r;
    logic [3:0]  bit_r;
    logic [2:0]  step_r;
    logic [8:0]  sh_r, rxs_r;
    logic [5:0]  left_r;
    logic        rd_r, sda_m, sda_s, scl_o_r, sda_o_r;
    logic [7:0]  sub_r;

    // ==========================================================
    // Quarter-bit tick and line levels for each element phase
    wire tick  = q_r == 16'(QCYC - 1);
    wire ack   = ~rxs_r[0];
    wire lastb = left_r == 6'h01;
    wire [8:0] rd_load = {8'hff, lastb};
    logic scl_lv, sda_lv;
    always_comb begin
        scl_lv = 1'b1;
        sda_lv = 1'b1;
        case (st_r)
            H_START: begin // Also serves as repeated start
                scl_lv = ph_r != 2'h0 && ph_r != 2'h3;
                sda_lv = ph_r < 2'h2;
            end
            H_BIT: begin
                scl_lv = ph_r == 2'h1 || ph_r == 2'h2;
                sda_lv = sh_r[8];
            end
            H_STOP: begin
                scl_lv = ph_r != 2'h0;
                sda_lv = ph_r >= 2'h2;
            end
            default: ;
        endcase
    end

    // ==========================================================
    // Sequencer; steps 0 address-w, 1 sub, 2 wdata, 3 address-r, 4 rdata
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= H_IDLE;
            q_r <= 16'h0;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            step_r <= 3'h0;
            sh_r <= 9'h1ff;
            rxs_r <= 9'h0;
            left_r <= 6'h0;
            rd_r <= 1'b0;
            sub_r <= 8'h0;
            {sda_m, sda_s, scl_o_r, sda_o_r} <= 4'hf;
            {o_wtake, o_rvalid, o_busy, o_nack, o_done} <= 5'h0;
            o_rbyte <= 8'h0;
        end else begin
            {sda_m, sda_s} <= {bus.sda, sda_m};
            {scl_o_r, sda_o_r} <= {scl_lv, sda_lv};
            {o_wtake, o_rvalid, o_done} <= 3'h0;
            q_r <= (st_r == H_IDLE || tick) ? 16'h0 : q_r + 16'h1;
            if (st_r == H_IDLE) begin
                o_busy <= i_go;
                if (i_go) begin
                    st_r <= H_START;
                    {ph_r, step_r} <= 5'h00;
                    {rd_r, sub_r, left_r, o_nack} <= {i_read, i_sub, i_count, 1'b0};
                end
            end else if (tick) begin
                ph_r <= ph_r + 2'h1;
                if (st_r == H_BIT && ph_r == 2'h2) rxs_r <= {rxs_r[7:0], sda_s};
                if (ph_r == 2'h3) begin
                    case (st_r)
                        H_START: begin
                            st_r  <= H_BIT;
                            bit_r <= 4'h0;
                            sh_r  <= {`ICCB_DEV_ADDR, step_r == 3'h3, 1'b1};
                        end
                        H_STOP: begin
                            st_r <= H_IDLE;
                            {o_busy, o_done} <= 2'h1;
                        end
                        H_BIT: begin
                            bit_r <= bit_r + 4'h1;
                            sh_r  <= {sh_r[7:0], 1'b1};
                            if (bit_r == 4'h8) begin
                                bit_r <= 4'h0;
                                if (step_r != 3'h4 && !ack) begin
                                    st_r   <= H_STOP;
                                    o_nack <= 1'b1;
                                end else begin
                                    case (step_r)
                                        3'h0: {step_r, sh_r} <= {3'h1, sub_r, 1'b1};
                                        3'h1: begin
                                            if (rd_r) begin
                                                st_r   <= H_START;
                                                step_r <= 3'h3;
                                            end else begin
                                                {step_r, sh_r} <= {3'h2, i_wbyte, 1'b1};
                                                o_wtake <= 1'b1;
                                            end
                                        end
                                        3'h2: begin
                                            left_r <= left_r - 6'h01;
                                            if (lastb) begin
                                                st_r <= H_STOP;
                                            end else begin
                                                sh_r    <= {i_wbyte, 1'b1};
                                                o_wtake <= 1'b1;
                                            end
                                        end
                                        3'h3: {step_r, sh_r} <= {3'h4, rd_load};
                                        default: begin
                                            {o_rbyte, o_rvalid} <= {rxs_r[8:1], 1'b1};
                                            left_r <= left_r - 6'h01;
                                            sh_r   <= {8'hff, left_r == 6'h02};
                                            if (lastb) st_r <= H_STOP;
                                        end
                                    endcase
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    assign bus.m_scl_oe_n = scl_o_r;
    assign bus.m_sda_oe_n = sda_o_r;
endmodule

// [testbench/iccb_assertions.sv]
// Checker of the two-wire control bus
`timescale 1ns/1ns
`include "iccb_map.svh"
module iccb_assertions (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic m_sda_oe_n,
    input wire logic s_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q, sda_q, fa, adr, rw;
    logic [3:0] bc;
    logic [7:0] sh;
    wire        cnd = scl & scl_q & (sda ^ sda_q);
    wire        ris = scl & ~scl_q;
    wire        ak  = ris & (bc == 4'h8);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ====================
    // Frame tracker; lines idle high, so reset copies start high
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {scl_q, sda_q} <= 2'h3;
            {fa, adr, rw, bc, sh} <= '0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (cnd) begin
                bc  <= 4'h0;
                fa  <= ~sda;
                adr <= adr & ~sda; // Stop drops the address
            end else if (ris) begin
                sh <= {sh[6:0], sda};
                bc <= ak ? 4'h0 : bc + 4'h1;
                fa <= fa & ~ak;
                if (ak && fa) begin
                    adr <= sh[7:1] == `ICCB_DEV_ADDR;
                    rw  <= sh[0];
                end
            end
        end
    end
    // ====================
    // Bus properties
    property p_scl_high; $rose(scl) |-> scl [*5]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("clock high too short");
    property p_scl_low; $fell(scl) |-> !scl [*5]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("clock low too short");
    property p_dev_low; $changed(s_sda_oe_n) |-> !scl; endproperty
    a_dev_low: assert property (p_dev_low) else $error("device moved data high");
    property p_adr_ack; ak && fa && sh[7:1] == `ICCB_DEV_ADDR |-> !s_sda_oe_n; endproperty
    a_adr_ack: assert property (p_adr_ack) else $error("address not acked");
    property p_wr_ack; ak && !fa && adr && !rw |-> !s_sda_oe_n; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("byte not acked");
    property p_rd_free; ak && !fa && adr && rw |-> s_sda_oe_n; endproperty
    a_rd_free: assert property (p_rd_free) else $error("device held ack slot");
    property p_start; scl && $fell(sda) |-> $fell(m_sda_oe_n); endproperty
    a_start: assert property (p_start) else $error("start not by host");
    property p_dev_rel; $fell(s_sda_oe_n) |-> ##[1:250] s_sda_oe_n; endproperty
    a_dev_rel: assert property (p_dev_rel) else $error("device never released");
endmodule

// [testbench/tb.sv]
// Testbench: host end and amplifier end on one bus
`timescale 1ns/1ns
module tb;
    import iccb_pkg::*;
    logic       clk = 0, rst = 1, go = 0, rd = 0, hp = 0;
    logic [7:0] sub = 0, wb = 0, vol, rb, wq [0:23], rq [0:23];
    logic [5:0] cnt = 1;
    logic [1:0] fs = 0, bl;
    logic [6:0] idx = 0;
    logic       rv, wt, nk, dn, bz, sdn, trm, uni, vce, eqb, drb, aut;
    iccb_coef_t cf;
    int         error_cnt = 0, compares = 0, cyc = 0;
    iccb_bus_if bus ();
    always #25 clk = ~clk;
    iccb_host_end u_iccb_host_end (.i_ref_clk(clk), .i_rst(rst), .bus(bus), .i_go(go),
        .i_read(rd), .i_sub(sub), .i_count(cnt), .i_wbyte(wb), .o_wtake(wt), .o_rbyte(rb),
        .o_rvalid(rv), .o_busy(bz), .o_nack(nk), .o_done(dn));
    iccb_dev_end u_iccb_dev_end (.i_ref_clk(clk), .i_rst(rst), .bus(bus), .i_fs_class(fs),
        .i_headphone(hp), .i_coef_idx(idx), .o_shutdown(sdn), .o_osc_factory_trim(trm),
        .o_unity_gain(uni), .o_volume(vol), .o_vol_comp_en(vce), .o_eq_bypass(eqb),
        .o_drc_bypass(drb), .o_auto_bank(aut), .o_bank_live(bl), .o_coef(cf));
    iccb_assertions u_iccb_assertions (.i_ref_clk(clk), .i_rst(rst), .m_sda_oe_n(bus.m_sda_oe_n),
        .s_sda_oe_n(bus.s_sda_oe_n), .scl(bus.scl), .sda(bus.sda));
    // ====================
    // Compare and close
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ====================
    // One transfer; bytes move at falling edges, after the pulses settle
    task automatic xfer(input logic r, input logic [7:0] s, input int n);
        int k, j, c;
        k = 0;
        j = 0;
        @(negedge clk);
        {rd, sub, cnt, wb} = {r, s, 6'(n), wq[0]};
        go = 1;
        @(negedge clk);
        go = 0;
        for (c = 0; c < 9000 && dn !== 1'b1; c++) begin
            @(negedge clk);
            if (wt === 1'b1) k++;
            wb = wq[k];
            if (rv === 1'b1) begin
                rq[j] = rb;
                j++;
            end
        end
        chk("done", 1, dn);
        chk("busy", 0, bz);
        chk("nack", 0, nk);
    endtask
    function automatic logic [31:0] cv(input logic [7:0] s, input logic [7:0] w);
        return {8'hcb, s, w, 8'h5a}; // Top bits set to expose the kept width
    endfunction
    task automatic wr(input logic [7:0] s, input logic [31:0] v, input int n);
        for (int b = 0; b < n; b++) wq[b] = v[8*(n-1-b) +: 8];
        xfer(0, s, n);
    endtask
    task automatic bq(input logic [7:0] s, input int n);
        logic [31:0] t;
        for (int i = 0; i < 20; i++) begin
            t = cv(s, 8'(i / 4));
            wq[i] = t[31-8*(i%4) -: 8];
        end
        xfer(0, 8'h29, n);
    endtask
    task automatic ckc(input logic [7:0] s);
        for (int w = 0; w < 5; w++) begin
            idx = 7'(w);
            @(negedge clk);
            chk("coef", cv(s, 8'(w)) & 32'h03ffffff, 32'(cf));
        end
    endtask
    // ====================
    // Scenarios
    task automatic t_regs;
        chk("sdn", 1, sdn);
        chk("trim", 0, trm);
        wr(8'h1b, 8'h00, 1);
        chk("trim", 1, trm);
        wr(8'h05, 8'h00, 1);
        chk("sdn", 0, sdn);
        wr(8'h07, 8'h30, 1);
        chk("unity", 1, uni);
        chk("vol", 8'h30, vol);
        wr(8'h0e, 1, 1);
        chk("vce", 1, vce);
        xfer(1, 8'h05, 3);
        chk("rd3", 32'h30, {rq[0], rq[1], rq[2]});
        wr(8'h26, 32'h12345678, 4);
        xfer(1, 8'h26, 4);
        chk("rd4", 32'h12345678, {rq[0], rq[1], rq[2], rq[3]});
        $display("regs done");
    endtask
    task automatic t_bank;
        bq(1, 20);
        ckc(1);
        bq(2, 8);
        ckc(1);
        wr(8'h50, 1, 4);
        bq(3, 20);
        ckc(1);
        wr(8'h50, 2, 4);
        bq(4, 20);
        wr(8'h50, 3, 4);
        bq(5, 20);
        xfer(1, 8'h29, 4);
        chk("rdc", cv(1, 0) & 32'h03ffffff, {rq[0], rq[1], rq[2], rq[3]});
        wr(8'h50, 4, 4);
        repeat (100) @(negedge clk);
        chk("auto", 1, aut);
        ckc(3);
        fs = 1;
        repeat (100) @(negedge clk);
        chk("live", 1, bl);
        ckc(4);
        hp = 1;
        repeat (5) @(negedge clk);
        chk("byp", 3, {eqb, drb});
        hp = 0;
        repeat (5) @(negedge clk);
        chk("byp", 0, {eqb, drb});
        $display("bank done");
    endtask
    // Watchdog: a hang ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        repeat (4) @(negedge clk);
        t_regs();
        t_bank();
        end_of_test();
    end
endmodule
